// *** logic/spa_top.sv ***
// Second serial port: four framing modes, multiprocessor address filter, AXI4-Lite registers.
//
// How it works
// [RULE1] Two mode bits choose one of four framings.
// [RULE2] Upper mode bit may act as framing error.
// [RULE3] Multiprocessor modes 2/3 drop ninth-bit-zero frames.
// [RULE4] Mode 1 multiprocessor needs a valid stop.
// [RULE5] Mode 0 shift clock: divide by 12 or 4.
// [RULE6] Receive only while receive enable is set.
// [RULE7] Modes 2/3 send the software ninth bit.
// [RULE8] Receive ninth bit: data bit or stop bit.
// [RULE9] Transmit done at eighth bit or stop start.
// [RULE10] Receive done at eighth bit or mid stop.
// [RULE11] Buffer reads receive data, writes start transmit.
// [RULE12] Mask bits select compared slave address bits.
// [RULE13] All-zero mask accepts every address.
// [RULE14] Software loads each port's own address and mask.
// [RULE15] Interrupt needs port enable and global enable.
// [RULE16] Priority bit picks high or low level.
// [RULE17] Receive and transmit lines are port-one alternates.
// [RULE18] Address frames count only on masked match.
// [RULE19] Mode 2 rate follows the doubling bit.
`timescale 1ns/10ps
`default_nettype none
`include "spa_params.svh"

module spa_top
(
	input  wire logic                 clk_i,
	input  wire logic                 rst_b_i,
	input  wire spa_pkg::spa_axi_req_t axi_req_i,
	output var  spa_pkg::spa_axi_rsp_t axi_rsp_o,
	input  wire logic                 port1_rx_pin_i,
	output var  logic                 port1_rx_pin_o,
	output var  logic                 port1_rx_pin_oe_o,
	output var  logic                 port1_tx_pin_o,
	output var  logic                 irq_o,
	output var  logic                 irq_high_o
);

	spa_pkg::spa_state_t s;
	spa_pkg::spa_state_t n;
	logic                tick;
	logic [1:0]          mode;
	logic                async_mode;
	logic [3:0]          last_bit;
	logic [3:0]          m0_period;
	logic [3:0]          m0_half;
	logic [7:0]          ridx;
	logic [7:0]          widx;
	logic [31:0]         rd_data;
	logic                rd_hit;
	logic                wr_hit;
	logic                do_wr;
	logic                buf_wr;
	logic                stop_bit;
	logic                addr_match;
	logic                accept;

	assign mode       = {s.frame_mode_hi, s.frame_mode_lo};
	assign async_mode = (mode != 2'b00);

	spa_bitclk u_bitclk
	(
		.clk_i        (clk_i),
		.rst_b_i      (rst_b_i),
		.fixed_rate_i (mode == 2'b10),
		.double_i     (s.baud_double),
		.divisor_i    (s.baud_div),
		.tick_o       (tick)
	);

	// ======================================================================
	// Next state
	// ======================================================================
	always_comb
	begin
		n          = s;
		ridx       = axi_req_i.araddr[9:2];
		widx       = s.waddr[9:2];
		rd_data    = 32'h00000000;
		rd_hit     = 1'b1;
		wr_hit     = 1'b1;
		do_wr      = s.aw_held && s.w_held && !s.rsp.bvalid;
		buf_wr     = 1'b0;
		stop_bit   = s.rx_s2;
		accept     = 1'b0;
		// Nine data bits in modes 2 and 3, eight otherwise. [RULE1]
		last_bit   = mode[1] ? `SPA_BITS_NINE : `SPA_BITS_EIGHT;
		m0_period  = s.multiproc_enable ? `SPA_M0_FAST_CLKS : `SPA_M0_SLOW_CLKS; // [RULE5]
		m0_half    = {1'b0, m0_period[3:1]};
		// Only masked positions are compared; an all-zero mask matches all. [RULE12] [RULE13]
		addr_match = (((s.rx_sh[7:0] ^ s.p1_port0_slave_address) & s.p1_mask) == 8'h00);

		// Pin inputs pass two flip-flops; the third serves edge detection.
		n.rx_s1 = port1_rx_pin_i; // [RULE17]
		n.rx_s2 = s.rx_s1;
		n.rx_s3 = s.rx_s2;

		// Read decode.
		unique case (ridx)
			`SPA_IDX_IRQ_ENABLE: rd_data[7:0] = s.irq_enable;
			`SPA_IDX_P0_PORT0_SLAVE_ADDRESS:   rd_data[7:0] = s.p0_port0_slave_address;
			`SPA_IDX_P1_PORT0_SLAVE_ADDRESS:   rd_data[7:0] = s.p1_port0_slave_address;
			`SPA_IDX_IRQ_PRIO:   rd_data[7:0] = {`SPA_IP_UNUSED_READ, s.irq_prio};
			`SPA_IDX_P0_MASK:    rd_data[7:0] = s.p0_mask;
			`SPA_IDX_P1_MASK:    rd_data[7:0] = s.p1_mask;
			`SPA_IDX_P1_CTRL:    rd_data[7:0] = {s.framing_flag_select ? s.framing_err_flag
				: s.frame_mode_hi, s.frame_mode_lo, s.multiproc_enable, s.rx_enable,
				s.tx_ninth_bit, s.rx_ninth_bit, s.tx_done_flag, s.rx_done_flag}; // [RULE2]
			`SPA_IDX_P1_BUF:     rd_data[7:0] = s.rx_buf; // [RULE11]
			`SPA_IDX_AUX_CTRL:   rd_data[1:0] = {s.baud_double, s.framing_flag_select};
			`SPA_IDX_BAUD_DIV:   rd_data[15:0] = s.baud_div;
			default:             rd_hit = 1'b0;
		endcase

		// Read channel: one read under way at a time.
		if (s.rsp.arready && axi_req_i.arvalid)
		begin
			n.rsp.arready = 1'b0;
			n.rsp.rvalid  = 1'b1;
			n.rsp.rdata   = rd_data;
			n.rsp.rresp   = rd_hit ? `SPA_RESP_OKAY : `SPA_RESP_SLVERR;
		end
		if (s.rsp.rvalid && axi_req_i.rready)
		begin
			n.rsp.rvalid  = 1'b0;
			n.rsp.arready = 1'b1;
		end

		// Write channels are taken in either order and held until both are in.
		if (s.rsp.awready && axi_req_i.awvalid)
		begin
			n.rsp.awready = 1'b0;
			n.aw_held     = 1'b1;
			n.waddr       = axi_req_i.awaddr;
		end
		if (s.rsp.wready && axi_req_i.wvalid)
		begin
			n.rsp.wready = 1'b0;
			n.w_held     = 1'b1;
			n.wdata      = axi_req_i.wdata;
			n.wstrb      = axi_req_i.wstrb;
		end
		if (do_wr)
		begin
			n.aw_held = 1'b0;
			n.w_held  = 1'b0;
			unique case (widx)
				`SPA_IDX_IRQ_ENABLE:
					if (s.wstrb[0]) n.irq_enable = s.wdata[7:0];
				`SPA_IDX_P0_PORT0_SLAVE_ADDRESS:
					if (s.wstrb[0]) n.p0_port0_slave_address = s.wdata[7:0]; // [RULE14]
				`SPA_IDX_P1_PORT0_SLAVE_ADDRESS:
					if (s.wstrb[0]) n.p1_port0_slave_address = s.wdata[7:0]; // [RULE14]
				`SPA_IDX_IRQ_PRIO:
					if (s.wstrb[0]) n.irq_prio = s.wdata[6:0];
				`SPA_IDX_P0_MASK:
					if (s.wstrb[0]) n.p0_mask = s.wdata[7:0];
				`SPA_IDX_P1_MASK:
					if (s.wstrb[0]) n.p1_mask = s.wdata[7:0];
				`SPA_IDX_P1_CTRL:
					if (s.wstrb[0])
					begin
						// The top bit lands in whichever role the select bit gives it. [RULE2]
						if (s.framing_flag_select)
							n.framing_err_flag = s.wdata[7];
						else
							n.frame_mode_hi = s.wdata[7];
						n.frame_mode_lo    = s.wdata[6];
						n.multiproc_enable = s.wdata[5];
						n.rx_enable        = s.wdata[4];
						n.tx_ninth_bit     = s.wdata[3];
						n.rx_ninth_bit     = s.wdata[2];
						n.tx_done_flag     = s.wdata[1];
						n.rx_done_flag     = s.wdata[0];
					end
				`SPA_IDX_P1_BUF:
					buf_wr = s.wstrb[0]; // [RULE11]
				`SPA_IDX_AUX_CTRL:
					if (s.wstrb[0])
					begin
						n.framing_flag_select = s.wdata[`SPA_AUX_FSEL_BIT];
						n.baud_double         = s.wdata[`SPA_AUX_DOUBLE_BIT];
					end
				`SPA_IDX_BAUD_DIV:
				begin
					if (s.wstrb[0]) n.baud_div[7:0]  = s.wdata[7:0];
					if (s.wstrb[1]) n.baud_div[15:8] = s.wdata[15:8];
				end
				default:
					wr_hit = 1'b0;
			endcase
			n.rsp.bvalid = 1'b1;
			n.rsp.bresp  = wr_hit ? `SPA_RESP_OKAY : `SPA_RESP_SLVERR;
		end
		if (s.rsp.bvalid && axi_req_i.bready)
		begin
			n.rsp.bvalid  = 1'b0;
			n.rsp.awready = 1'b1;
			n.rsp.wready  = 1'b1;
		end

		// A buffer write starts a frame only when the port is idle; otherwise it is dropped.
		if (buf_wr && s.tx_st == spa_pkg::SPA_TX_IDLE && s.sy_st == spa_pkg::SPA_SY_IDLE)
		begin
			if (async_mode)
			begin
				n.tx_st     = spa_pkg::SPA_TX_START;
				n.tx_tick   = 4'h0;
				n.tx_sh     = {s.tx_ninth_bit, s.wdata[7:0]}; // [RULE7]
				n.pin.tx_o  = 1'b0;
			end
			else
			begin
				n.sy_st     = spa_pkg::SPA_SY_TX;
				n.sy_div    = 4'h0;
				n.sy_cnt    = 4'h0;
				n.sy_sh     = s.wdata[7:0];
				n.pin.rx_o  = s.wdata[0];
				n.pin.rx_oe = 1'b1;
				n.pin.tx_o  = 1'b0;
			end
		end

		// ==================================================================
		// Asynchronous transmitter, sixteen ticks per bit
		// ==================================================================
		if (s.tx_st != spa_pkg::SPA_TX_IDLE && tick)
		begin
			n.tx_tick = s.tx_tick + 4'h1;
			if (s.tx_tick == `SPA_OVS_LAST)
			begin
				unique case (s.tx_st)
					spa_pkg::SPA_TX_START:
					begin
						n.tx_st    = spa_pkg::SPA_TX_DATA;
						n.tx_cnt   = 4'h0;
						n.pin.tx_o = s.tx_sh[0];
						n.tx_sh    = {1'b0, s.tx_sh[8:1]};
					end
					spa_pkg::SPA_TX_DATA:
						if (s.tx_cnt == last_bit)
						begin
							n.tx_st        = spa_pkg::SPA_TX_STOP;
							n.pin.tx_o     = 1'b1;
							n.tx_done_flag = 1'b1; // [RULE9]
						end
						else
						begin
							n.tx_cnt   = s.tx_cnt + 4'h1;
							n.pin.tx_o = s.tx_sh[0];
							n.tx_sh    = {1'b0, s.tx_sh[8:1]};
						end
					spa_pkg::SPA_TX_STOP:
						n.tx_st = spa_pkg::SPA_TX_IDLE;
					default:
						n.tx_st = spa_pkg::SPA_TX_IDLE;
				endcase
			end
		end

		// ==================================================================
		// Asynchronous receiver
		// ==================================================================
		if (!s.rx_enable || !async_mode)
			n.rx_st = spa_pkg::SPA_RX_IDLE; // [RULE6]
		else if (s.rx_st == spa_pkg::SPA_RX_IDLE)
		begin
			if (s.rx_s3 && !s.rx_s2)
			begin
				n.rx_st   = spa_pkg::SPA_RX_START;
				n.rx_tick = 4'h0;
			end
		end
		else if (tick)
		begin
			n.rx_tick = s.rx_tick + 4'h1;
			unique case (s.rx_st)
				spa_pkg::SPA_RX_START:
					if (s.rx_tick == `SPA_OVS_MID)
					begin
						n.rx_tick = 4'h0;
						n.rx_cnt  = 4'h0;
						n.rx_st   = s.rx_s2 ? spa_pkg::SPA_RX_IDLE : spa_pkg::SPA_RX_DATA;
					end
				spa_pkg::SPA_RX_DATA:
					if (s.rx_tick == `SPA_OVS_LAST)
					begin
						n.rx_sh  = {s.rx_s2, s.rx_sh[8:1]};
						n.rx_cnt = s.rx_cnt + 4'h1;
						if (s.rx_cnt == last_bit)
							n.rx_st = spa_pkg::SPA_RX_STOP;
					end
				spa_pkg::SPA_RX_STOP:
					if (s.rx_tick == `SPA_OVS_LAST)
					begin
						n.rx_st = spa_pkg::SPA_RX_IDLE;
						if (s.framing_flag_select && !stop_bit)
							n.framing_err_flag = 1'b1; // [RULE2]
						if (!mode[1])
							accept = !s.multiproc_enable || stop_bit; // [RULE4]
						else
							accept = !s.multiproc_enable
								|| (s.rx_sh[8] && addr_match); // [RULE3] [RULE18]
						if (accept && !s.rx_done_flag)
						begin
							n.rx_buf       = mode[1] ? s.rx_sh[7:0] : s.rx_sh[8:1];
							n.rx_ninth_bit = mode[1] ? s.rx_sh[8] : stop_bit; // [RULE8]
							n.rx_done_flag = 1'b1; // [RULE10]
						end
					end
				default:
					n.rx_st = spa_pkg::SPA_RX_IDLE;
			endcase
		end

		// ==================================================================
		// Synchronous shifter: data on the receive line, clock on transmit line
		// ==================================================================
		if (s.sy_st == spa_pkg::SPA_SY_IDLE)
		begin
			if (!async_mode && s.rx_enable && !s.rx_done_flag && !n.pin.rx_oe)
			begin
				n.sy_st    = spa_pkg::SPA_SY_RX; // [RULE6]
				n.sy_div   = 4'h0;
				n.sy_cnt   = 4'h0;
				n.pin.tx_o = 1'b0;
			end
		end
		else if (s.sy_st == spa_pkg::SPA_SY_RX && !s.rx_enable)
		begin
			n.sy_st    = spa_pkg::SPA_SY_IDLE;
			n.pin.tx_o = 1'b1;
		end
		else
		begin
			n.sy_div = s.sy_div + 4'h1;
			if (s.sy_div == m0_half - 4'h1)
				n.pin.tx_o = 1'b1;
			if (s.sy_div == m0_period - 4'h1)
			begin
				n.sy_div = 4'h0;
				n.sy_cnt = s.sy_cnt + 4'h1;
				n.sy_sh  = (s.sy_st == spa_pkg::SPA_SY_RX) ? {s.rx_s2, s.sy_sh[7:1]}
					: {1'b0, s.sy_sh[7:1]};
				n.pin.rx_o = (s.sy_st == spa_pkg::SPA_SY_TX) ? s.sy_sh[1] : 1'b1;
				if (s.sy_cnt == `SPA_BITS_EIGHT)
				begin
					n.sy_st     = spa_pkg::SPA_SY_IDLE;
					n.pin.rx_oe = 1'b0;
					n.pin.rx_o  = 1'b1;
					n.pin.tx_o  = 1'b1;
					if (s.sy_st == spa_pkg::SPA_SY_TX)
						n.tx_done_flag = 1'b1; // [RULE9]
					else
					begin
						n.rx_buf       = {s.rx_s2, s.sy_sh[7:1]};
						n.rx_done_flag = 1'b1; // [RULE10]
					end
				end
				else
					n.pin.tx_o = 1'b0;
			end
		end

		// Request needs both enables; the priority bit names the level. [RULE15] [RULE16]
		n.irq = (n.rx_done_flag || n.tx_done_flag) && n.irq_enable[`SPA_IE_PORT1_BIT]
			&& n.irq_enable[`SPA_IE_GLOBAL_BIT];
		n.irq_high = n.irq_prio[`SPA_IP_PORT1_BIT];
	end

	// ======================================================================
	// State register
	// ======================================================================
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			s                     <= '0;
			s.rsp.awready         <= 1'b1;
			s.rsp.wready          <= 1'b1;
			s.rsp.arready         <= 1'b1;
			s.irq_enable          <= `SPA_BYTE_RST;
			s.p0_port0_slave_address            <= `SPA_BYTE_RST;
			s.p0_mask             <= `SPA_BYTE_RST;
			s.p1_port0_slave_address            <= `SPA_BYTE_RST;
			s.p1_mask             <= `SPA_BYTE_RST;
			s.irq_prio            <= `SPA_IP_RST;
			s.baud_div            <= `SPA_DIV_RST;
			s.tx_st               <= spa_pkg::SPA_TX_IDLE;
			s.rx_st               <= spa_pkg::SPA_RX_IDLE;
			s.sy_st               <= spa_pkg::SPA_SY_IDLE;
			s.rx_s1               <= 1'b1;
			s.rx_s2               <= 1'b1;
			s.rx_s3               <= 1'b1;
			s.pin.rx_o            <= 1'b1;
			s.pin.tx_o            <= 1'b1;
		end
		else
			s <= n;
	end

	assign axi_rsp_o         = s.rsp;
	assign port1_rx_pin_o    = s.pin.rx_o;
	assign port1_rx_pin_oe_o = s.pin.rx_oe;
	assign port1_tx_pin_o    = s.pin.tx_o;
	assign irq_o             = s.irq;
	assign irq_high_o        = s.irq_high;

endmodule
`default_nettype wire

// *** logic/spa_params.svh ***
// Constants for the serial port with address recognition: indices, fields, resets, counts.
`ifndef SPA_PARAMS_SVH
`define SPA_PARAMS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define SPA_IDX_IRQ_ENABLE   8'hA8
`define SPA_IDX_P0_PORT0_SLAVE_ADDRESS     8'hA9
`define SPA_IDX_P1_PORT0_SLAVE_ADDRESS     8'hAA
`define SPA_IDX_IRQ_PRIO     8'hB8
`define SPA_IDX_P0_MASK      8'hB9
`define SPA_IDX_P1_MASK      8'hBA
`define SPA_IDX_P1_CTRL      8'hC0
`define SPA_IDX_P1_BUF       8'hC1
`define SPA_IDX_AUX_CTRL     8'hD0
`define SPA_IDX_BAUD_DIV     8'hD1

// ==========================================================================
// Field positions
// ==========================================================================
`define SPA_IE_GLOBAL_BIT    7
`define SPA_IE_PORT1_BIT     6
`define SPA_IP_PORT1_BIT     6
`define SPA_AUX_FSEL_BIT     0
`define SPA_AUX_DOUBLE_BIT   1

// ==========================================================================
// Reset values
// ==========================================================================
`define SPA_BYTE_RST         8'h00
`define SPA_IP_RST           7'h00
`define SPA_IP_UNUSED_READ   1'b1
`define SPA_DIV_RST          16'h0000

// ==========================================================================
// Timing counts in system clocks and oversampling ticks, and bit counts
// ==========================================================================
`define SPA_M0_SLOW_CLKS     4'hC
`define SPA_M0_FAST_CLKS     4'h4
`define SPA_M2_TICK_SLOW     16'h0003
`define SPA_M2_TICK_FAST     16'h0001
`define SPA_OVS_LAST         4'hF
`define SPA_OVS_MID          4'h7
`define SPA_BITS_EIGHT       4'h7
`define SPA_BITS_NINE        4'h8

// ==========================================================================
// Bus answers
// ==========================================================================
`define SPA_RESP_OKAY        2'h0
`define SPA_RESP_SLVERR      2'h2

`endif

// *** logic/spa_pkg.sv ***
// Types shared by the serial port with address recognition.
package spa_pkg;

	typedef enum logic [3:0]
	{
		SPA_TX_IDLE  = 4'h1,
		SPA_TX_START = 4'h2,
		SPA_TX_DATA  = 4'h4,
		SPA_TX_STOP  = 4'h8
	} spa_tx_state_t;

	typedef enum logic [3:0]
	{
		SPA_RX_IDLE  = 4'h1,
		SPA_RX_START = 4'h2,
		SPA_RX_DATA  = 4'h4,
		SPA_RX_STOP  = 4'h8
	} spa_rx_state_t;

	typedef enum logic [2:0]
	{
		SPA_SY_IDLE = 3'h1,
		SPA_SY_TX   = 3'h2,
		SPA_SY_RX   = 3'h4
	} spa_sync_state_t;

	typedef struct packed
	{
		logic [9:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [9:0]  araddr;
		logic        arvalid;
		logic        rready;
	} spa_axi_req_t;

	typedef struct packed
	{
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} spa_axi_rsp_t;

	typedef struct packed
	{
		logic rx_o;
		logic rx_oe;
		logic tx_o;
	} spa_pin_t;

	typedef struct packed
	{
		logic [15:0] cnt;
		logic        tick;
	} spa_bitclk_state_t;

	typedef struct packed
	{
		spa_axi_rsp_t    rsp;
		logic [9:0]      waddr;
		logic [31:0]     wdata;
		logic [3:0]      wstrb;
		logic            aw_held;
		logic            w_held;
		logic [7:0]      irq_enable;
		logic [7:0]      p0_port0_slave_address;
		logic [7:0]      p0_mask;
		logic [7:0]      p1_port0_slave_address;
		logic [7:0]      p1_mask;
		logic [6:0]      irq_prio;
		logic            frame_mode_hi;
		logic            frame_mode_lo;
		logic            multiproc_enable;
		logic            rx_enable;
		logic            tx_ninth_bit;
		logic            rx_ninth_bit;
		logic            tx_done_flag;
		logic            rx_done_flag;
		logic            framing_err_flag;
		logic            framing_flag_select;
		logic            baud_double;
		logic [15:0]     baud_div;
		logic [7:0]      rx_buf;
		spa_tx_state_t   tx_st;
		logic [3:0]      tx_tick;
		logic [3:0]      tx_cnt;
		logic [8:0]      tx_sh;
		spa_rx_state_t   rx_st;
		logic [3:0]      rx_tick;
		logic [3:0]      rx_cnt;
		logic [8:0]      rx_sh;
		spa_sync_state_t sy_st;
		logic [3:0]      sy_div;
		logic [3:0]      sy_cnt;
		logic [7:0]      sy_sh;
		logic            rx_s1;
		logic            rx_s2;
		logic            rx_s3;
		spa_pin_t        pin;
		logic            irq;
		logic            irq_high;
	} spa_state_t;

endpackage

// *** logic/spa_bitclk.sv ***
// Oversampling tick generator, sixteen ticks per serial bit.
`timescale 1ns/10ps
`default_nettype none
`include "spa_params.svh"

module spa_bitclk
(
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        fixed_rate_i,
	input  wire logic        double_i,
	input  wire logic [15:0] divisor_i,
	output var  logic        tick_o
);

	spa_pkg::spa_bitclk_state_t s;
	spa_pkg::spa_bitclk_state_t next_s;
	logic [15:0]                reload;

	// ======================================================================
	// Counter
	// ======================================================================
	always_comb
	begin
		next_s = s;
		// The fixed-rate mode gives 64 clocks per bit, or 32 when doubled. [RULE19]
		if (fixed_rate_i)
			reload = double_i ? `SPA_M2_TICK_FAST : `SPA_M2_TICK_SLOW;
		else
			reload = divisor_i;
		next_s.tick = 1'b0;
		if (s.cnt == 16'h0000)
		begin
			next_s.cnt  = reload;
			next_s.tick = 1'b1;
		end
		else if (s.cnt > reload)
			next_s.cnt = reload;
		else
			next_s.cnt = s.cnt - 16'h0001;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign tick_o = s.tick;

endmodule
`default_nettype wire

// *** sim/spa_checker.sv ***
// Bus and pin assertions for the serial port with address recognition.
`timescale 1ns/10ps
`default_nettype none
`include "spa_params.svh"

module spa_checker
(
	input wire logic                  clk_i,
	input wire logic                  rst_b_i,
	input wire spa_pkg::spa_axi_req_t axi_req_i,
	input wire spa_pkg::spa_axi_rsp_t axi_rsp_o,
	input wire logic                  port1_rx_pin_i,
	input wire logic                  port1_rx_pin_o,
	input wire logic                  port1_rx_pin_oe_o,
	input wire logic                  port1_tx_pin_o,
	input wire logic                  irq_o,
	input wire logic                  irq_high_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_write_answer: assert property (axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid
		&& axi_rsp_o.wready |-> ##[1:3] axi_rsp_o.bvalid)
		else $error("write response late");
	a_bresp_taken: assert property (axi_rsp_o.bvalid && axi_req_i.bready |=> !axi_rsp_o.bvalid)
		else $error("write response not released");
	a_aw_blocked: assert property (axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready)
		else $error("write accepted while response pending");
	a_read_answer: assert property (axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid)
		else $error("read data late");
	a_rdata_taken: assert property (axi_rsp_o.rvalid && axi_req_i.rready
		|=> !axi_rsp_o.rvalid && axi_rsp_o.arready)
		else $error("read data not released");
	a_unmapped_read: assert property (axi_req_i.arvalid && axi_rsp_o.arready
		&& !(axi_req_i.araddr[9:2] inside {8'hA8, 8'hA9, 8'hAA, 8'hB8, 8'hB9, 8'hBA,
		8'hC0, 8'hC1, 8'hD0, 8'hD1})
		|=> axi_rsp_o.rresp == `SPA_RESP_SLVERR && axi_rsp_o.rdata == 32'h0)
		else $error("unmapped read not refused");
	a_prio_top_bit: assert property (axi_req_i.arvalid && axi_rsp_o.arready
		&& axi_req_i.araddr[9:2] == 8'hB8 |=> axi_rsp_o.rdata[7])
		else $error("priority top bit not high");
	a_rx_idle_high: assert property (!port1_rx_pin_oe_o |-> port1_rx_pin_o)
		else $error("receive line output not idle high");
endmodule

bind spa_top spa_checker i_chk
(
	.clk_i(clk_i), .rst_b_i(rst_b_i), .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o),
	.port1_rx_pin_i(port1_rx_pin_i), .port1_rx_pin_o(port1_rx_pin_o),
	.port1_rx_pin_oe_o(port1_rx_pin_oe_o), .port1_tx_pin_o(port1_tx_pin_o),
	.irq_o(irq_o), .irq_high_o(irq_high_o)
);
`default_nettype wire

// *** sim/spa_link_model.sv ***
// Serial partner that drives mode 2 frames and samples the transmit line.
`timescale 1ns/10ps
`default_nettype none

module spa_link_model
(
	input  wire logic clk_i,
	input  wire logic tx_i,
	output var  logic rx_o
);
	localparam int CPB = 64;

	initial rx_o = 1'b1;

	task automatic send(input logic [7:0] v, input logic n9, input logic sp);
		logic [10:0] fr;
		fr = {sp, n9, v, 1'b0};
		@(posedge clk_i);
		for (int i = 0; i < 11; i++)
		begin
			rx_o <= fr[i];
			repeat (CPB) @(posedge clk_i);
		end
		rx_o <= 1'b1;
	endtask

	// Samples each bit in its middle, timed from the falling start edge.
	task automatic take(output logic [10:0] fr);
		while (tx_i !== 1'b0)
			@(negedge clk_i);
		repeat (CPB / 2) @(negedge clk_i);
		for (int i = 0; i < 11; i++)
		begin
			fr[i] = tx_i;
			repeat (CPB) @(negedge clk_i);
		end
	endtask
endmodule
`default_nettype wire

// *** sim/spa_top_tb.sv ***
// Self-checking bench for the serial port with address recognition.
`timescale 1ns/10ps
`default_nettype none
`include "spa_params.svh"

module spa_top_tb;
	logic                  clk_i;
	logic                  rst_b_i;
	spa_pkg::spa_axi_req_t req;
	spa_pkg::spa_axi_rsp_t rsp;
	logic                  pin;
	logic                  mdl;
	logic                  rx_o;
	logic                  rx_oe;
	logic                  tx;
	logic                  irq;
	logic                  irq_hi;
	logic [7:0]            d;
	logic [7:0]            eb;
	logic [1:0]            r;
	logic [10:0]           f;
	logic [7:0]            msk [4] = '{8'hF0, 8'hF0, 8'hF0, 8'h00};
	logic [7:0]            dat [4] = '{8'h53, 8'h63, 8'h53, 8'hC3};
	logic [3:0]            n9      = 4'hB;
	logic [3:0]            acc     = 4'h9;
	int                    err_total = 0;
	int                    n_checks  = 0;
	int                    cyc       = 0;
	int                    t0        = 0;

	assign pin = rx_oe ? rx_o : mdl;

	spa_top i_dut
	(
		.clk_i(clk_i), .rst_b_i(rst_b_i), .axi_req_i(req), .axi_rsp_o(rsp),
		.port1_rx_pin_i(pin), .port1_rx_pin_o(rx_o), .port1_rx_pin_oe_o(rx_oe),
		.port1_tx_pin_o(tx), .irq_o(irq), .irq_high_o(irq_hi)
	);

	spa_link_model i_link
	(
		.clk_i(clk_i), .tx_i(tx), .rx_o(mdl)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			print_verdict();
		end
	end

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic ta;
		logic tw;
		logic tb;
		@(posedge clk_i);
		req.awaddr <= {a, 2'h0};
		req.wdata <= {24'h0, v};
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do
		begin
			@(negedge clk_i);
			ta = req.awvalid & rsp.awready;
			tw = req.wvalid & rsp.wready;
			tb = rsp.bvalid;
			r = rsp.bresp;
			@(posedge clk_i);
			if (ta)
				req.awvalid <= 1'b0;
			if (tw)
				req.wvalid <= 1'b0;
		end while (tb !== 1'b1);
		req.bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		logic ta;
		logic tv;
		@(posedge clk_i);
		req.araddr <= {a, 2'h0};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do
		begin
			@(negedge clk_i);
			ta = req.arvalid & rsp.arready;
			tv = rsp.rvalid;
			d = rsp.rdata[7:0];
			r = rsp.rresp;
			@(posedge clk_i);
			if (ta)
				req.arvalid <= 1'b0;
		end while (tv !== 1'b1);
		req.rready <= 1'b0;
	endtask

	initial
	begin
		req = '0;
		rst_b_i = 1'b0;
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(`SPA_IDX_P1_CTRL);
		chk("ctrl", 8'h00, d);
		rd(`SPA_IDX_IRQ_PRIO);
		chk("prio", 8'h80, d);
		rd(8'h10);
		chk("rresp", {6'h0, `SPA_RESP_SLVERR}, {6'h0, r});
		wr(8'h10, 8'hFF);
		chk("bresp", {6'h0, `SPA_RESP_SLVERR}, {6'h0, r});
		wr(`SPA_IDX_P1_PORT0_SLAVE_ADDRESS, 8'h5A);
		rd(`SPA_IDX_P1_PORT0_SLAVE_ADDRESS);
		chk("port0_slave_address", 8'h5A, d);
		$display("test registers done");
		for (int n = 0; n < 2; n++)
		begin
			wr(`SPA_IDX_P1_CTRL, {4'h8, 1'(n), 3'h0});
			fork
				wr(`SPA_IDX_P1_BUF, 8'hA5);
				i_link.take(f);
			join
			chk("tx data", 8'hA5, f[8:1]);
			chk("tx frame", {5'h0, 1'b1, 1'(n), 1'b0}, {5'h0, f[10:9], f[0]});
			rd(`SPA_IDX_P1_CTRL);
			chk("tx done", {4'h8, 1'(n), 3'h2}, d);
		end
		$display("test transmit done");
		eb = 8'h00;
		for (int k = 0; k < 4; k++)
		begin
			wr(`SPA_IDX_P1_MASK, msk[k]);
			wr(`SPA_IDX_P1_CTRL, 8'hB0);
			i_link.send(dat[k], n9[k], 1'b1);
			rd(`SPA_IDX_P1_CTRL);
			chk("rx done", {7'h0, acc[k]}, {7'h0, d[0]});
			if (acc[k])
				eb = dat[k];
			rd(`SPA_IDX_P1_BUF);
			chk("rx buf", eb, d);
		end
		wr(`SPA_IDX_P1_CTRL, 8'hA0);
		i_link.send(8'h77, 1'b1, 1'b1);
		rd(`SPA_IDX_P1_CTRL);
		chk("rx off", 8'hA0, d);
		$display("test filter done");
		wr(`SPA_IDX_P1_CTRL, 8'h90);
		i_link.send(8'h3C, 1'b1, 1'b1);
		rd(`SPA_IDX_P1_CTRL);
		chk("ninth", 8'h95, d);
		for (int k = 0; k < 4; k++)
		begin
			wr(`SPA_IDX_IRQ_ENABLE, {2'(k), 6'h0});
			repeat (2) @(negedge clk_i);
			chk("irq", {7'h0, k == 3}, {7'h0, irq});
		end
		wr(`SPA_IDX_P1_CTRL, 8'h90);
		repeat (2) @(negedge clk_i);
		chk("irq clr", 8'h00, {7'h0, irq});
		wr(`SPA_IDX_IRQ_PRIO, 8'h40);
		repeat (2) @(negedge clk_i);
		chk("irq high", 8'h01, {7'h0, irq_hi});
		$display("test interrupt done");
		wr(`SPA_IDX_BAUD_DIV, 8'h03);
		wr(`SPA_IDX_P1_CTRL, 8'h70);
		i_link.send(8'h2D, 1'b0, 1'b1);
		rd(`SPA_IDX_P1_CTRL);
		chk("m1 bad stop", 8'h70, d);
		wr(`SPA_IDX_P1_CTRL, 8'h50);
		i_link.send(8'h2D, 1'b1, 1'b1);
		rd(`SPA_IDX_P1_CTRL);
		chk("m1 stop bit", 8'h55, d);
		rd(`SPA_IDX_P1_BUF);
		chk("m1 data", 8'h2D, d);
		for (int n = 0; n < 2; n++)
		begin
			wr(`SPA_IDX_P1_CTRL, {2'h0, 1'(n), 5'h00});
			fork
				wr(`SPA_IDX_P1_BUF, 8'hC6);
				for (int i = 0; i < 8; i++)
				begin
					@(posedge tx);
					@(negedge clk_i);
					eb[i] = rx_o;
					if (i == 0)
						t0 = cyc;
					if (i == 0)
						chk("m0 oe", 8'h01, {7'h0, rx_oe});
					if (i == 1)
						chk("m0 period", n ? 8'h04 : 8'h0C, 8'(cyc - t0));
				end
			join
			chk("m0 data", 8'hC6, eb);
			repeat (8) @(posedge clk_i);
			rd(`SPA_IDX_P1_CTRL);
			chk("m0 done", {2'h0, 1'(n), 5'h02}, d);
		end
		wr(`SPA_IDX_P1_CTRL, 8'h80);
		$display("test modes done");
		wr(`SPA_IDX_AUX_CTRL, 8'h01);
		wr(`SPA_IDX_P1_CTRL, 8'h10);
		i_link.send(8'h11, 1'b1, 1'b0);
		rd(`SPA_IDX_P1_CTRL);
		chk("frame err", 8'h95, d);
		wr(`SPA_IDX_P1_CTRL, 8'h10);
		rd(`SPA_IDX_P1_CTRL);
		chk("fe clear", 8'h10, d);
		$display("test framing done");
		print_verdict();
	end
endmodule
`default_nettype wire
